/* rtl/protected_register_access.sv */
// protected register access: operating memory, key levels, nv copy engine
// Function
// - every location readable at any level
// - level changes after two key writes
// - 0xCD then 0xF0 enters full write
// - key read returns 0x00, 0x01, 0x03
// - read-only level blocks all writes except key bytes and the 0x4E load command
// - limited level writes lock and burst regs
// - full level writes every location
// - levels nest; full reports limited bit
// - lookup and scratch at 0x40..0x7F
// - power-up loads store automatically
// - command 0x4E loads store contents
// - command 0xE4 stores region to store at full level only
// - busy bit high during load/store
// - corrected error flag on repaired bit
// - uncorrectable flag on bad load data
// - works at 100 and 400 kbit/s
// - multi-byte bursts; block mode bounds them
// - bytes travel msb first
// - receiver acknowledges every byte
// - stop resets register pointer to 0x00
// - eight-bit writes take effect immediately
// - 12-bit value updates on low byte
// - burst past size+1 wraps to start
`timescale 1ns/1ns
`default_nettype none
module protected_register_access (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // i2c pins
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // nonvolatile store port (word per address, corrected/uncorrectable flag pair)
  output logic [5:0] nv_addr,
  output logic [7:0] nv_wdata,
  output logic nv_we,
  input wire logic [7:0] nv_rdata,
  input wire logic [1:0] nv_err,
  // state views
  output logic [1:0] level_out,
  output logic busy_out,
  output logic [11:0] value12_out
);
  typedef enum logic [1:0] {
    C_IDLE = 2'b00,
    C_LOAD = 2'b01,
    C_STORE = 2'b10
  } copy_state_t;

  logic start_p, stop_p, wr_p, first_data, rd_req_p;
  logic [7:0] wr_data;
  logic [7:0] rd_byte;
  logic [7:0] mem_q [pra_pkg::MEM_DEPTH];
  logic [7:0] ptr_q, burst_base_q;
  logic [6:0] burst_cnt_q;
  logic [1:0] level_q;
  logic key_armed_q;
  logic [7:0] key_first_q;
  logic [7:0] lock_q, blk_q;
  logic [3:0] hi_pend_q;
  logic [11:0] value12_q;
  copy_state_t cst_q;
  logic [5:0] cidx_q;
  logic [3:0] step_q;
  logic cor_q, uncorrectable_error_flag_q;
  logic boot_q;
  logic wr_ok;
  logic cmd_load, cmd_store;
  logic [7:0] cur_addr;

  // bus bit engine
  i2c_byte_slave u_bits (
    .clk(clk),
    .rstn(rstn),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .start_p(start_p),
    .stop_p(stop_p),
    .wr_p(wr_p),
    .wr_data(wr_data),
    .first_data(first_data),
    .rd_req_p(rd_req_p),
    .rd_data(rd_byte)
  );

  // write permission per level and target
  function automatic logic allowed(input logic [1:0] lvl,
                                   input logic [7:0] a);
    if (lvl == 2'b11) begin
      allowed = 1'b1;
    end else if (lvl == 2'b01) begin
      allowed = (a == pra_pkg::SLAVE_ADDRESS_LOCK_ADDR) ||
                (a == pra_pkg::BURST_LENGTH_CONTROL_ADDR);
    end else begin
      allowed = 1'b0;
    end
  endfunction

  // first data byte of a write sets the pointer, later ones carry data
  assign cur_addr = ptr_q;
  assign wr_ok = wr_p && !first_data && allowed(level_q, cur_addr) &&
                 cur_addr < 8'(pra_pkg::MEM_DEPTH);
  assign cmd_load = wr_p && !first_data &&
                    cur_addr == pra_pkg::NONVOLATILE_COMMAND_STATUS_ADDR &&
                    wr_data == pra_pkg::CMD_LOAD && cst_q == C_IDLE;
  assign cmd_store = wr_p && !first_data && level_q == 2'b11 &&
                     cur_addr == pra_pkg::NONVOLATILE_COMMAND_STATUS_ADDR &&
                     wr_data == pra_pkg::CMD_STORE && cst_q == C_IDLE;

  // read mux; read access never depends on level, only the key byte reports it
  always_comb begin
    if (cur_addr == pra_pkg::ACCESS_LEVEL_KEY_ADDR) begin
      if (level_q == 2'b11) rd_byte = pra_pkg::LEVEL_FULL;
      else if (level_q == 2'b01) rd_byte = pra_pkg::LEVEL_LIMITED;
      else rd_byte = pra_pkg::LEVEL_RO;
    end else if (cur_addr == pra_pkg::NONVOLATILE_COMMAND_STATUS_ADDR) begin
      rd_byte = 8'h00;
      rd_byte[pra_pkg::BUSY_BIT] = cst_q != C_IDLE;
      rd_byte[pra_pkg::COR_BIT] = cor_q;
      rd_byte[pra_pkg::UNCORRECTABLE_ERROR_FLAG_BIT] = uncorrectable_error_flag_q;
    end else if (cur_addr == pra_pkg::SLAVE_ADDRESS_LOCK_ADDR) begin
      rd_byte = lock_q;
    end else if (cur_addr == pra_pkg::BURST_LENGTH_CONTROL_ADDR) begin
      rd_byte = blk_q;
    end else if (cur_addr == pra_pkg::HI_NIBBLE_ADDR) begin
      rd_byte = {4'h0, value12_q[11:8]};
    end else if (cur_addr == pra_pkg::LO_BYTE_ADDR) begin
      rd_byte = value12_q[7:0];
    end else if (cur_addr < 8'(pra_pkg::MEM_DEPTH)) begin
      rd_byte = mem_q[cur_addr[6:0]];
    end else begin
      rd_byte = 8'h00;
    end
  end

  // register pointer: set by first byte, advances, wraps, cleared on stop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ptr_q <= 8'h00;
      burst_base_q <= 8'h00;
      burst_cnt_q <= 7'h00;
    end else if (stop_p) begin
      ptr_q <= 8'h00;
      burst_cnt_q <= 7'h00;
    end else if (wr_p && first_data) begin
      ptr_q <= wr_data;
      burst_base_q <= wr_data;
      burst_cnt_q <= 7'h00;
    end else if ((wr_p && !first_data) || (rd_req_p && !start_p)) begin
      // wrap after size+1 transfers when limiting is on
      if (blk_q[pra_pkg::BLK_EN_BIT] && burst_cnt_q == blk_q[6:0]) begin
        ptr_q <= burst_base_q;
        burst_cnt_q <= 7'h00;
      end else begin
        ptr_q <= ptr_q + 8'h01;
        burst_cnt_q <= burst_cnt_q + 7'h01;
      end
    end
  end

  // key sequence; level moves only on a matched second byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      level_q <= 2'b00;
      key_armed_q <= 1'b0;
      key_first_q <= 8'h00;
    end else if (wr_p && !first_data) begin
      if (cur_addr == pra_pkg::ACCESS_LEVEL_KEY_ADDR) begin
        if (!key_armed_q) begin
          key_armed_q <= 1'b1;
          key_first_q <= wr_data;
        end else begin
          key_armed_q <= 1'b0; // mismatch restarts the sequence
          if (key_first_q == pra_pkg::KEY_L2_FIRST &&
              wr_data == pra_pkg::KEY_L2_SECOND) begin
            level_q <= 2'b11;
          end else if (key_first_q == pra_pkg::KEY_L1_FIRST &&
                       wr_data == pra_pkg::KEY_L1_SECOND) begin
            level_q <= 2'b01;
          end else if (key_first_q == pra_pkg::KEY_L0_FIRST &&
                       wr_data == pra_pkg::KEY_L0_SECOND) begin
            level_q <= 2'b00;
          end else if (wr_data == pra_pkg::KEY_L2_FIRST ||
                       wr_data == pra_pkg::KEY_L1_FIRST) begin
            key_armed_q <= 1'b1; // a fresh L1 or L2 first byte rearms
            key_first_q <= wr_data;
          end
        end
      end else begin
        key_armed_q <= 1'b0; // writes must be back to back
      end
    end
  end

  // eight-bit control registers take effect at byte end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      lock_q <= 8'h00;
      blk_q <= pra_pkg::BLK_RESET;
    end else if (wr_ok) begin
      if (cur_addr == pra_pkg::SLAVE_ADDRESS_LOCK_ADDR) lock_q <= wr_data;
      if (cur_addr == pra_pkg::BURST_LENGTH_CONTROL_ADDR) blk_q <= wr_data;
    end
  end

  // split 12-bit value: nibble waits for the low byte
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hi_pend_q <= 4'h0;
      value12_q <= 12'h000;
    end else if (wr_ok) begin
      if (cur_addr == pra_pkg::HI_NIBBLE_ADDR) hi_pend_q <= wr_data[3:0];
      if (cur_addr == pra_pkg::LO_BYTE_ADDR) value12_q <= {hi_pend_q, wr_data};
    end
  end

  // copy engine between store and the lookup region
  always_ff @(posedge clk) begin
    if (!rstn) begin
      cst_q <= C_IDLE;
      cidx_q <= 6'h00;
      step_q <= 4'h0;
      cor_q <= 1'b0;
      uncorrectable_error_flag_q <= 1'b0;
      boot_q <= 1'b1;
      nv_we <= 1'b0;
    end else begin
      nv_we <= 1'b0;
      case (cst_q)
        C_IDLE: begin
          step_q <= 4'h0;
          cidx_q <= 6'h00;
          if (boot_q || cmd_load) begin
            boot_q <= 1'b0;
            cst_q <= C_LOAD;
            cor_q <= 1'b0;
            uncorrectable_error_flag_q <= 1'b0;
          end else if (cmd_store) begin
            cst_q <= C_STORE;
          end
        end
        C_LOAD, C_STORE: begin
          if (step_q == pra_pkg::STEP_CYCLES - 4'h1) begin
            step_q <= 4'h0;
            if (cst_q == C_LOAD) begin
              if (nv_err[0]) cor_q <= 1'b1;
              if (nv_err[1]) uncorrectable_error_flag_q <= 1'b1;
            end else begin
              nv_we <= 1'b1;
            end
            if (cidx_q == 6'(pra_pkg::LUT_WORDS - 1)) cst_q <= C_IDLE;
            cidx_q <= cidx_q + 6'h01;
          end else begin
            step_q <= step_q + 4'h1;
          end
        end
        default: cst_q <= C_IDLE;
      endcase
    end
  end

  // store port address and data follow the copy index
  always_ff @(posedge clk) begin
    if (!rstn) begin
      nv_addr <= 6'h00;
      nv_wdata <= 8'h00;
    end else begin
      nv_addr <= cidx_q;
      nv_wdata <= mem_q[{1'b1, cidx_q}];
    end
  end

  // operating memory; loads take priority over bus writes
  genvar g;
  generate
    for (g = 0; g < pra_pkg::MEM_DEPTH; g++) begin : g_mem
      always_ff @(posedge clk) begin
        if (!rstn) begin
          mem_q[g] <= 8'h00;
        end else if (cst_q == C_LOAD && g >= 64 &&
                     step_q == pra_pkg::STEP_CYCLES - 4'h1 &&
                     cidx_q == 6'(g - 64)) begin
          mem_q[g] <= nv_rdata;
        end else if (wr_ok && cur_addr == 8'(g)) begin
          mem_q[g] <= wr_data;
        end
      end
    end
  endgenerate

  // state views
  always_ff @(posedge clk) begin
    if (!rstn) begin
      level_out <= 2'b00;
      busy_out <= 1'b0;
      value12_out <= 12'h000;
    end else begin
      level_out <= level_q;
      busy_out <= cst_q != C_IDLE;
      value12_out <= value12_q;
    end
  end
endmodule
`default_nettype wire

/* rtl/pra_pkg.sv */
// package: register offsets, key codes, commands and timing for the access front end
package pra_pkg;
  // register offsets inside operating memory
  localparam logic [7:0] ACCESS_LEVEL_KEY_ADDR = 8'h01;
  localparam logic [7:0] NONVOLATILE_COMMAND_STATUS_ADDR = 8'h02;
  localparam logic [7:0] SLAVE_ADDRESS_LOCK_ADDR = 8'h03;
  localparam logic [7:0] BURST_LENGTH_CONTROL_ADDR = 8'h04;
  localparam logic [7:0] HI_NIBBLE_ADDR = 8'h10;
  localparam logic [7:0] LO_BYTE_ADDR = 8'h11;
  localparam logic [7:0] LUT_FIRST_ADDR = 8'h40;
  localparam logic [7:0] LUT_LAST_ADDR = 8'h7f;
  localparam int MEM_DEPTH = 128;
  localparam int LUT_WORDS = 64;
  // key bytes per level
  localparam logic [7:0] KEY_L1_FIRST = 8'hab;
  localparam logic [7:0] KEY_L1_SECOND = 8'hba;
  localparam logic [7:0] KEY_L2_FIRST = 8'hcd;
  localparam logic [7:0] KEY_L2_SECOND = 8'hf0;
  localparam logic [7:0] KEY_L0_FIRST = 8'h00;
  localparam logic [7:0] KEY_L0_SECOND = 8'hff;
  // level status codes
  localparam logic [7:0] LEVEL_RO = 8'h00;
  localparam logic [7:0] LEVEL_LIMITED = 8'h01;
  localparam logic [7:0] LEVEL_FULL = 8'h03;
  // nonvolatile commands
  localparam logic [7:0] CMD_LOAD = 8'h4e;
  localparam logic [7:0] CMD_STORE = 8'he4;
  // status field positions
  localparam int BUSY_BIT = 0;
  localparam int COR_BIT = 1;
  localparam int UNCORRECTABLE_ERROR_FLAG_BIT = 2;
  // burst control fields
  localparam int BLK_EN_BIT = 7;
  // address lock enable bit
  localparam int LOCK_EN_BIT = 0;
  // burst control reset value: block mode off
  localparam logic [7:0] BLK_RESET = 8'h00;
  // cycles per nonvolatile word step
  localparam int STEP_NS = 100;
  localparam int CLK_NS = 10;
  localparam logic [3:0] STEP_CYCLES = 4'((STEP_NS + CLK_NS - 1) / CLK_NS);
  // slave address (no pin decode in this block)
  localparam logic [6:0] SLAVE_ADDR = 7'h40;
endpackage

/* rtl/i2c_byte_slave.sv */
// i2c slave bit engine: start/stop, address match, byte shift and ack
`timescale 1ns/1ns
`default_nettype none
module i2c_byte_slave (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus pins (oe low drives sda low)
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  // byte interface
  output logic start_p,
  output logic stop_p,
  output logic wr_p,
  output logic [7:0] wr_data,
  output logic first_data,
  output logic rd_req_p,
  input wire logic [7:0] rd_data
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_ADDR = 3'b001,
    S_AACK = 3'b010,
    S_WR = 3'b011,
    S_WACK = 3'b100,
    S_RD = 3'b101,
    S_RACK = 3'b110
  } bit_state_t;
  logic [2:0] scl_s, sda_s;
  logic scl_q, sda_q, scl_prev_q, sda_prev_q;
  bit_state_t st_q;
  logic [7:0] sh_q;
  logic [3:0] cnt_q;
  logic first_q;
  logic rise, fall, start_c, stop_c;

  // three-stage sync; a level counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_s <= 3'b111;
      sda_s <= 3'b111;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
      if (scl_s[1] == scl_s[2]) scl_q <= scl_s[2];
      if (sda_s[1] == sda_s[2]) sda_q <= sda_s[2];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_prev_q <= scl_q;
      sda_prev_q <= sda_q;
    end
  end

  assign rise = scl_q && !scl_prev_q;
  assign fall = !scl_q && scl_prev_q;
  assign start_c = scl_q && scl_prev_q && sda_prev_q && !sda_q;
  assign stop_c = scl_q && scl_prev_q && !sda_prev_q && sda_q;

  // protocol sequencer; sampling on rise keeps it rate independent
  always_ff @(posedge clk) begin
    if (!rstn) begin
      st_q <= S_IDLE;
      sh_q <= 8'h00;
      cnt_q <= 4'h0;
      first_q <= 1'b0;
      sda_out <= 1'b1;
      sda_oe_n <= 1'b1;
      start_p <= 1'b0;
      stop_p <= 1'b0;
      wr_p <= 1'b0;
      wr_data <= 8'h00;
      first_data <= 1'b0;
      rd_req_p <= 1'b0;
    end else begin
      start_p <= start_c;
      stop_p <= stop_c;
      wr_p <= 1'b0;
      rd_req_p <= 1'b0;
      if (start_c) begin
        st_q <= S_ADDR;
        cnt_q <= 4'h0;
        sda_oe_n <= 1'b1;
      end else if (stop_c) begin
        st_q <= S_IDLE;
        sda_oe_n <= 1'b1;
      end else begin
        case (st_q)
          S_IDLE: begin
            sda_oe_n <= 1'b1;
          end
          S_ADDR, S_WR: begin
            if (rise) begin
              sh_q <= {sh_q[6:0], sda_q}; // msb first
              cnt_q <= cnt_q + 4'h1;
            end else if (fall && cnt_q == 4'h8) begin
              cnt_q <= 4'h0;
              if (st_q == S_ADDR) begin
                if (sh_q[7:1] == pra_pkg::SLAVE_ADDR) begin
                  sda_oe_n <= 1'b0; // ack the address
                  sda_out <= 1'b0;
                  st_q <= S_AACK;
                  first_q <= 1'b1; // next written byte sets the pointer
                end else begin
                  st_q <= S_IDLE;
                end
              end else begin
                sda_oe_n <= 1'b0; // ack each written byte
                sda_out <= 1'b0;
                wr_p <= 1'b1;
                wr_data <= sh_q;
                first_data <= first_q;
                first_q <= 1'b0;
                st_q <= S_WACK;
              end
            end
          end
          S_AACK, S_WACK: begin
            if (fall) begin
              if (st_q == S_AACK && sh_q[0]) begin
                st_q <= S_RD;
                sda_oe_n <= rd_data[7]; // read data msb first
                sda_out <= 1'b0;
                sh_q <= {rd_data[6:0], 1'b1};
                cnt_q <= 4'h1;
              end else begin
                sda_oe_n <= 1'b1;
                st_q <= S_WR;
              end
            end
          end
          S_RD: begin
            if (fall) begin
              if (cnt_q == 4'h8) begin
                sda_oe_n <= 1'b1; // release for master ack
                st_q <= S_RACK;
              end else begin
                sda_oe_n <= sh_q[7];
                sh_q <= {sh_q[6:0], 1'b1};
                cnt_q <= cnt_q + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (rise) begin
              if (sda_q) begin
                st_q <= S_IDLE; // master nak ends reading
              end else begin
                rd_req_p <= 1'b1;
              end
            end else if (fall) begin
              st_q <= S_RD;
              sda_oe_n <= rd_data[7];
              sh_q <= {rd_data[6:0], 1'b1};
              cnt_q <= 4'h1;
            end
          end
          default: st_q <= S_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

/* bench/pra_sva.sv */
// checker: port timing and protection assertions for the access block
`timescale 1ns/1ns
`default_nettype none
module pra_sva (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bus pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  // store port
  input wire logic [5:0] nv_addr,
  input wire logic [7:0] nv_wdata,
  input wire logic nv_we,
  input wire logic [7:0] nv_rdata,
  input wire logic [1:0] nv_err,
  // state views
  input wire logic [1:0] level_out,
  input wire logic busy_out,
  input wire logic [11:0] value12_out
);
  localparam int BUSY_MAX = 700;
  logic [5:0] since_fall_q;
  logic [9:0] busy_cnt_q;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  // age of the last scl fall; state only moves right after a byte ends
  always_ff @(posedge clk) begin
    if (!rstn || $fell(scl_in)) begin
      since_fall_q <= 6'h00;
    end else if (since_fall_q != 6'h3f) begin
      since_fall_q <= since_fall_q + 6'h01;
    end
  end
  // length of the current copy, bounded so a stuck engine is seen
  always_ff @(posedge clk) begin
    if (!rstn || !busy_out) begin
      busy_cnt_q <= 10'h000;
    end else if (busy_cnt_q != 10'h3ff) begin
      busy_cnt_q <= busy_cnt_q + 10'h001;
    end
  end
  a_drive_low: assert property (!sda_oe_n |-> !sda_out)
    else $error("sda driven high");
  a_sda_steady: assert property
    (scl_in && $past(scl_in) |-> $stable(sda_oe_n))
    else $error("sda moved while scl high");
  a_level_code: assert property (level_out != 2'b10)
    else $error("full level without limited bit");
  a_we_single: assert property (nv_we |=> !nv_we [*8])
    else $error("store write not a single pulse");
  a_we_in_busy: assert property (nv_we |-> busy_out)
    else $error("store write while idle");
  a_we_full: assert property (nv_we |-> level_out == 2'b11)
    else $error("store write below full level");
  a_level_by_bus: assert property
    ($changed(level_out) |-> since_fall_q < 6'h10)
    else $error("level moved without a byte");
  a_value_on_low: assert property
    ($changed(value12_out) |-> since_fall_q < 6'h10)
    else $error("value moved without a byte");
  a_busy_bound: assert property (busy_cnt_q < BUSY_MAX)
    else $error("copy too long");
  c_copy_done: cover property ($fell(busy_out));
  c_full: cover property (level_out == 2'b11);
  c_store: cover property (nv_we);
  c_value: cover property ($changed(value12_out));
endmodule
bind protected_register_access pra_sva u_sva (.clk, .rstn, .scl_in,
  .sda_in, .sda_out, .sda_oe_n, .nv_addr, .nv_wdata, .nv_we, .nv_rdata,
  .nv_err, .level_out, .busy_out, .value12_out);
`default_nettype wire

/* bench/i2c_master_model.sv */
// bus master model: bit-level transfers paced by the bench clock
`timescale 1ns/1ns
`default_nettype none
module i2c_master_model (
  // clock
  input wire logic clk,
  // bus lines (released sda reads 1 through the pull-up)
  output logic scl,
  output logic sda_o,
  input wire logic sda,
  // read results
  output logic rd_valid,
  output logic [7:0] rd_byte
);
  int q = 5;
  int nacks = 0;
  // idle bus at time zero
  initial begin
    scl = 1'b1;
    sda_o = 1'b1;
    rd_valid = 1'b0;
    rd_byte = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // data set while scl low, sampled mid-high where it is settled
  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    tick(q);
    scl <= 1'b1;
    tick(q);
    r = sda;
    tick(q);
    scl <= 1'b0;
    tick(q);
  endtask
  task automatic start_c();
    sda_o <= 1'b1;
    tick(q);
    scl <= 1'b1;
    tick(q);
    sda_o <= 1'b0; // sda falls with scl high
    tick(q);
    scl <= 1'b0;
    tick(q);
  endtask
  task automatic stop_c();
    sda_o <= 1'b0;
    tick(q);
    scl <= 1'b1;
    tick(q);
    sda_o <= 1'b1;
    tick(q);
  endtask
  task automatic byte_io(input logic [7:0] d, input logic ack_in,
                         output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(ack_in, ack);
  endtask
  // byte to the device; a missing ack is counted
  task automatic send(input logic [7:0] d);
    logic [7:0] r;
    logic a;
    byte_io(d, 1'b1, r, a);
    if (a !== 1'b0) nacks++;
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
    start_c();
    send({pra_pkg::SLAVE_ADDR, 1'b0});
    send(p);
    foreach (d[i]) send(d[i]);
    stop_c();
  endtask
  // optional pointer phase, then a repeated start into the read
  task automatic rd(input logic set_p, input logic [7:0] p, input int n);
    logic [7:0] r;
    logic a;
    if (set_p) begin
      start_c();
      send({pra_pkg::SLAVE_ADDR, 1'b0});
      send(p);
    end
    start_c();
    send({pra_pkg::SLAVE_ADDR, 1'b1});
    for (int i = 0; i < n; i++) begin
      byte_io(8'hff, i == n - 1, r, a); // nak ends the read
      rd_byte <= r;
      rd_valid <= 1'b1;
      tick(1);
      rd_valid <= 1'b0;
    end
    stop_c();
  endtask
endmodule
`default_nettype wire

/* bench/tb_protected_register_access.sv */
// bench: drives the access block through its bus pins and store port
`timescale 1ns/1ns
`default_nettype none
module tb_protected_register_access;
  localparam logic [7:0] A_KEY = pra_pkg::ACCESS_LEVEL_KEY_ADDR;
  localparam logic [7:0] A_NV = pra_pkg::NONVOLATILE_COMMAND_STATUS_ADDR;
  localparam logic [7:0] A_BLK = pra_pkg::BURST_LENGTH_CONTROL_ADDR;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scl, sda_o, sda, sda_out, sda_oe_n, nv_we, busy_out, rd_valid;
  logic [5:0] nv_addr;
  logic [7:0] nv_wdata, rd_byte, d0, d1, d2;
  logic [7:0] nv_rdata = 8'h00;
  logic [1:0] nv_err = 2'b00;
  logic [1:0] level_out;
  logic [11:0] value12_out;
  logic [7:0] nv_mem [64];
  logic err_on = 1'b0;
  logic [31:0] seed = 32'h274df3ed;
  logic [7:0] exp_q [$];
  int error_cnt = 0;
  int compares = 0;
  // open-drain wire: either side may pull low
  assign sda = sda_o & (sda_oe_n | sda_out);
  initial forever #5 clk = ~clk;
  protected_register_access DUT (.clk, .rstn, .scl_in(scl), .sda_in(sda),
    .sda_out, .sda_oe_n, .nv_addr, .nv_wdata, .nv_we, .nv_rdata, .nv_err,
    .level_out, .busy_out, .value12_out);
  i2c_master_model m (.clk, .scl, .sda_o, .sda, .rd_valid, .rd_byte);
  // store: one-cycle read latency, flags on words 5 and 6 when armed
  always @(posedge clk) begin
    nv_rdata <= nv_mem[nv_addr];
    nv_err <= err_on ? {nv_addr == 6'h06, nv_addr == 6'h05} : 2'b00;
    if (nv_we) nv_mem[nv_addr] <= nv_wdata;
  end
  initial for (int i = 0; i < 64; i++) nv_mem[i] = 8'(i * 7 + 3);
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic rnd(output logic [7:0] r);
    seed = lfsr(seed);
    r = seed[7:0];
  endtask
  task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic chk_port(input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr1(input logic [7:0] p, input logic [7:0] d);
    m.wr(p, '{d});
  endtask
  task automatic rd1(input logic [7:0] p, input logic [7:0] e);
    exp_q.push_back(e);
    m.rd(1'b1, p, 1);
  endtask
  // bounded wait for the copy engine to go idle
  task automatic wait_idle();
    int n = 0;
    while (busy_out !== 1'b0 && n < 2000) begin
      @(posedge clk);
      n++;
    end
    if (n == 2000) error_cnt++;
  endtask
  // result watcher: each read byte meets the oldest note
  always @(posedge clk) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) error_cnt++;
      else chk_byte(exp_q.pop_front(), rd_byte);
    end
  end
  // watchdog: the sequence needs about 65k cycles
  initial begin
    repeat (95000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end
  initial begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk); // busy view is registered behind the engine
    #1;
    chk_port(12'h001, 12'(busy_out));
    m.q = 4;
    rd1(A_NV, 8'h01);
    m.q = 5;
    wait_idle();
    rd1(A_NV, 8'h00);
    exp_q.push_back(nv_mem[0]);
    exp_q.push_back(nv_mem[1]);
    m.rd(1'b1, 8'h40, 2);
    rd1(8'h7f, nv_mem[63]);
    rd1(A_KEY, pra_pkg::LEVEL_RO);
    wr1(8'h40, 8'h5a);
    wr1(A_BLK, 8'h81);
    rd1(8'h40, nv_mem[0]);
    rd1(A_BLK, pra_pkg::BLK_RESET);
    wr1(A_KEY, pra_pkg::KEY_L1_FIRST);
    wr1(A_KEY, pra_pkg::KEY_L1_SECOND);
    rd1(A_KEY, pra_pkg::LEVEL_LIMITED);
    wr1(pra_pkg::SLAVE_ADDRESS_LOCK_ADDR, 8'h01);
    rd1(pra_pkg::SLAVE_ADDRESS_LOCK_ADDR, 8'h01);
    wr1(8'h41, 8'h3c);
    rd1(8'h41, nv_mem[1]);
    wr1(A_KEY, pra_pkg::KEY_L2_FIRST);
    wr1(A_KEY, 8'h11);
    rd1(A_KEY, pra_pkg::LEVEL_LIMITED);
    wr1(A_KEY, pra_pkg::KEY_L2_FIRST);
    wr1(A_KEY, pra_pkg::KEY_L2_SECOND);
    rd1(A_KEY, pra_pkg::LEVEL_FULL);
    chk_port(12'h003, 12'(level_out));
    rnd(d0);
    rnd(d1);
    rnd(d2);
    wr1(8'h00, d0);
    exp_q.push_back(d0);
    m.rd(1'b0, 8'h00, 1);
    wr1(8'h40, d1);
    rd1(8'h40, d1);
    wr1(pra_pkg::HI_NIBBLE_ADDR, 8'h0a);
    chk_port(12'h000, value12_out);
    wr1(pra_pkg::LO_BYTE_ADDR, d2);
    chk_port({4'ha, d2}, value12_out);
    wr1(A_NV, pra_pkg::CMD_STORE);
    chk_port(12'h001, 12'(busy_out));
    wait_idle();
    chk_byte(d1, nv_mem[0]);
    nv_mem[2] = 8'hc3;
    err_on <= 1'b1;
    wr1(A_NV, pra_pkg::CMD_LOAD);
    wait_idle();
    err_on <= 1'b0;
    rd1(8'h42, 8'hc3);
    rd1(A_NV, 8'h06);
    wr1(A_BLK, 8'h81);
    m.wr(8'h50, '{8'h11, 8'h22, 8'h33});
    rd1(8'h50, 8'h33);
    rd1(8'h51, 8'h22);
    m.q = 250;
    wr1(8'h21, d2);
    m.q = 63;
    rd1(8'h21, d2);
    chk_port(12'h000, 12'(m.nacks));
    chk_port(12'h000, 12'(exp_q.size()));
    wrap_up();
  end
endmodule
`default_nettype wire
